/* rtl/bbsa_pkg.sv */
package bbsa_pkg;
  // bus widths
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int DEPTH = 2048;
  // clock and pin timing in ns
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_WRITE_PULSE_NS = 75;
  localparam int T_DATA_SETUP_NS = 35;
  localparam int T_DATA_HOLD_NS = 5;
  localparam int T_ADDR_HOLD_NS = 10;
  localparam int T_ADDR_ACCESS_NS = 120;
  localparam int T_OE_ACCESS_NS = 75;
  localparam int T_WE_FLOAT_NS = 40;
  localparam int T_CE_FLOAT_NS = 30;
  // least times round up, at least one cycle
  function automatic int bbsa_min_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : bbsa_min_cyc
  localparam int WR_PULSE_CYC = bbsa_min_cyc(T_WRITE_PULSE_NS);
  localparam int DATA_SETUP_CYC = bbsa_min_cyc(T_DATA_SETUP_NS);
  localparam int DATA_HOLD_CYC = bbsa_min_cyc(T_DATA_HOLD_NS);
  localparam int ADDR_HOLD_CYC = bbsa_min_cyc(T_ADDR_HOLD_NS);
  // read waits cover the device's longest times, plus one cycle for input sampling
  localparam int RD_WAIT_CYC = bbsa_min_cyc(T_ADDR_ACCESS_NS) + 1;
  localparam int FLOAT_CYC = bbsa_min_cyc(T_WE_FLOAT_NS);
  localparam int CE_FLOAT_CYC = bbsa_min_cyc(T_CE_FLOAT_NS);
  localparam logic [7:0] INIT_CNT = 8'h00;
  // host command and answer
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bbsa_cmd_s;
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic batt_low;
  } bbsa_rsp_s;
endpackage : bbsa_pkg

/* rtl/bbsa_timer.sv */
`timescale 1ns/1ps
// down counter: load a count, done stays high while idle at zero
module bbsa_timer #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] cnt_q;
  // count down from the loaded value
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= count;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end
  // done ignores load so the loader may use it without a combinational loop
  assign done = (cnt_q == '0);
endmodule : bbsa_timer

/* rtl/bbsa_ctrl.sv */
`timescale 1ns/1ps
module bbsa_ctrl #(
  parameter int ADDR_W = bbsa_pkg::ADDR_W,
  parameter int DATA_W = bbsa_pkg::DATA_W
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic power_ok,
  input wire logic req_valid,
  input wire bbsa_pkg::bbsa_cmd_s req_cmd,
  input wire logic batt_test,
  output logic req_ready,
  output logic rsp_valid,
  output bbsa_pkg::bbsa_rsp_s rsp,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [ADDR_W-1:0] byte_address_bus,
  output logic [DATA_W-1:0] data_io_out,
  output logic data_io_oe,
  input wire logic [DATA_W-1:0] data_io_in
);
  typedef enum logic [3:0] {
    S_INIT, S_IDLE, S_RD_SET, S_RD_WAIT, S_RD_DONE,
    S_WR_SET, S_WR_PULSE, S_WR_HOLD, S_RECOVER
  } bbsa_state_e;
  typedef enum logic [2:0] {
    B_NONE, B_READ1, B_WRCOMP, B_READ2, B_RESTORE
  } bbsa_bt_e;
  bbsa_state_e st_q;
  bbsa_bt_e bt_q;
  logic tload;
  logic [7:0] tcount;
  logic tdone;
  logic [DATA_W-1:0] s1_q, s2_q, s3_q;
  logic [DATA_W-1:0] orig_q;
  logic cur_write_q;
  logic [DATA_W-1:0] cur_data_q;
  logic req_take;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] rd_q;
  // one delay timer serves every phase
  bbsa_timer #(.W(8)) u_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .load(tload),
    .count(tcount),
    .done(tdone)
  );
  // three-stage pin sampling, data used once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= data_io_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // read byte moves only once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_q <= '0;
    end else if (s2_q == s3_q) begin
      rd_q <= s3_q;
    end
  end
  assign rd_word = rd_q;
  // only accept work with power good and the machine idle
  assign req_take = (st_q == S_IDLE) && power_ok && (req_valid || batt_test) && tdone;
  // timer load per state entry
  always_comb begin
    tload = 1'b0;
    tcount = 8'h00;
    if (sys_rst) begin
      tload = 1'b0;
    end else if (req_take) begin
      tload = 1'b1;
      tcount = 8'(bbsa_pkg::FLOAT_CYC);
    end else if (st_q == S_RD_SET && tdone) begin
      tload = 1'b1;
      tcount = 8'(bbsa_pkg::RD_WAIT_CYC);
    end else if (st_q == S_WR_SET && tdone) begin
      tload = 1'b1;
      tcount = 8'(bbsa_pkg::WR_PULSE_CYC);
    end else if (st_q == S_WR_PULSE && tdone) begin
      tload = 1'b1;
      tcount = 8'(bbsa_pkg::DATA_HOLD_CYC);
    end else if ((st_q == S_WR_HOLD || st_q == S_RD_DONE) && tdone) begin
      tload = 1'b1;
      tcount = 8'(bbsa_pkg::ADDR_HOLD_CYC);
    end else if (st_q == S_INIT && tdone) begin
      tload = 1'b0;
    end
  end
  // main access sequencer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= S_INIT;
    end else if (!power_ok) begin
      st_q <= S_RECOVER; // abandon the cycle while deselected
    end else begin
      case (st_q)
        S_INIT: begin
          if (tdone) begin
            st_q <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (req_take) begin
            st_q <= (batt_test || !req_cmd.write) ? S_RD_SET : S_WR_SET;
          end
        end
        S_RD_SET: if (tdone) st_q <= S_RD_WAIT;
        S_RD_WAIT: if (tdone) st_q <= S_RD_DONE;
        S_RD_DONE: st_q <= S_RECOVER;
        S_WR_SET: if (tdone) st_q <= S_WR_PULSE;
        S_WR_PULSE: if (tdone) st_q <= S_WR_HOLD;
        S_WR_HOLD: if (tdone) st_q <= S_RECOVER;
        S_RECOVER: begin
          if (tdone) begin
            st_q <= (bt_q != B_NONE && bt_q != B_READ1) ? S_RD_SET : S_IDLE;
            if (bt_q == B_WRCOMP || bt_q == B_RESTORE) begin
              st_q <= S_WR_SET;
            end
            if (bt_q == B_NONE) begin
              st_q <= S_IDLE;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  // battery test sequence: read, write complement, reread, restore only if the complement read back
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !power_ok) begin
      bt_q <= B_NONE;
    end else if (req_take && batt_test) begin
      bt_q <= B_READ1;
    end else if (st_q == S_RD_DONE && bt_q == B_READ1) begin
      bt_q <= B_WRCOMP;
    end else if (st_q == S_WR_HOLD && tdone && bt_q == B_WRCOMP) begin
      bt_q <= B_READ2;
    end else if (st_q == S_RD_DONE && bt_q == B_READ2) begin
      bt_q <= (rd_word == ~orig_q) ? B_RESTORE : B_NONE;
    end else if (st_q == S_WR_HOLD && tdone && bt_q == B_RESTORE) begin
      bt_q <= B_NONE;
    end
  end
  // current cycle data and saved original byte
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cur_write_q <= 1'b0;
      cur_data_q <= '0;
      orig_q <= '0;
      byte_address_bus <= '0;
    end else begin
      if (req_take) begin
        cur_write_q <= req_cmd.write && !batt_test;
        cur_data_q <= req_cmd.wdata;
        byte_address_bus <= req_cmd.addr; // held until next take
      end
      if (st_q == S_RD_DONE && bt_q == B_READ1) begin
        orig_q <= rd_word;
        cur_data_q <= ~rd_word;
      end
      if (st_q == S_RD_DONE && bt_q == B_READ2) begin
        cur_data_q <= orig_q;
      end
    end
  end
  // pin drive: chip enable, output enable, write enable, data
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      data_io_oe <= 1'b0;
      data_io_out <= '0;
    end else begin
      ce_n <= !(power_ok && (st_q == S_RD_SET || st_q == S_RD_WAIT ||
               st_q == S_WR_SET || st_q == S_WR_PULSE));
      oe_n <= !(power_ok && (st_q == S_RD_SET || st_q == S_RD_WAIT));
      we_n <= !(power_ok && st_q == S_WR_PULSE); // we rises with ce, two cycles before data is released
      data_io_oe <= power_ok && (st_q == S_WR_PULSE || st_q == S_WR_HOLD);
      data_io_out <= cur_data_q;
    end
  end
  // answer: read data and battery-low verdict
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
      req_ready <= 1'b0;
    end else begin
      req_ready <= (st_q == S_IDLE) && power_ok && tdone && !req_take;
      rsp_valid <= 1'b0;
      if (st_q == S_RD_DONE && bt_q == B_NONE && !cur_write_q) begin
        rsp_valid <= 1'b1;
        rsp.rdata <= rd_word;
      end else if (st_q == S_WR_HOLD && tdone && bt_q == B_NONE) begin
        rsp_valid <= 1'b1;
      end else if (st_q == S_RD_DONE && bt_q == B_READ2) begin
        rsp_valid <= 1'b1;
        rsp.rdata <= orig_q;
        rsp.batt_low <= (rd_word != ~orig_q);
      end
    end
  end
  // checks on pin timing
  sequence s_we_held_low;
    !we_n [*2];
  endsequence
  a_we_pulse_width: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(we_n) |-> s_we_held_low)
    else $error("write pulse too short");
  a_oe_high_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !we_n |-> oe_n)
    else $error("output enable low in write");
  a_addr_stable: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !ce_n && $past(!ce_n) |-> $stable(byte_address_bus))
    else $error("address moved in cycle");
  a_data_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(we_n) && power_ok |-> data_io_oe)
    else $error("data not held");
  a_no_contend: assert property (@(posedge sys_clk) disable iff (sys_rst)
    data_io_oe |-> oe_n)
    else $error("bus contention");
  a_ce_pwr_fail: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !$past(power_ok) |-> ce_n)
    else $error("chip enabled without power");
  a_we_in_ce: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !we_n |-> !ce_n)
    else $error("write outside chip enable");
  a_addr_recover: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(ce_n) |=> ce_n)
    else $error("no recovery after cycle");
endmodule : bbsa_ctrl

/* sim/bbsa_mem_model.sv */
`timescale 1ns/1ps
// pin-level model of the battery-backed byte memory
module bbsa_mem_model (
  input wire logic power_ok,
  input wire logic batt_bad,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [10:0] byte_address_bus,
  input wire logic [7:0] data_wr,
  output logic [7:0] data_rd,
  output logic data_drv
);
  logic [7:0] mem [0:2047];
  logic battery_low_flag = 1'b0;
  logic [7:0] last_q = 8'h00;
  wire wr_on = power_ok && !ce_n && !we_n;
  // known preload so reads can be predicted
  initial for (int i = 0; i < 2048; i++) mem[i] = i[7:0] ^ 8'h5A;
  // battery checked as supply returns
  always @(posedge power_ok) battery_low_flag = batt_bad;
  // store at the earlier rising enable; a power loss drops the byte
  always @(negedge wr_on) begin
    if (power_ok && battery_low_flag) battery_low_flag = 1'b0;
    else if (power_ok) mem[byte_address_bus] = data_wr;
  end
  // drive only in a powered read with outputs enabled
  assign data_drv = power_ok && !ce_n && !oe_n && we_n;
  // a released bus shows the inverse of the last byte driven
  always @(negedge data_drv) last_q = mem[byte_address_bus];
  assign data_rd = data_drv ? mem[byte_address_bus] : ~last_q;
endmodule : bbsa_mem_model

/* sim/battery_backed_sram_access_tb.sv */
`timescale 1ns/1ps
// bench for the battery-backed memory controller
module battery_backed_sram_access_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic power_ok = 1'b0;
  logic batt_bad = 1'b0;
  logic req_valid = 1'b0;
  logic batt_test = 1'b0;
  bbsa_pkg::bbsa_cmd_s req_cmd = '0;
  bbsa_pkg::bbsa_rsp_s rsp;
  logic req_ready, rsp_valid, ce_n, oe_n, we_n, data_io_oe, data_drv, ref_low;
  logic [10:0] byte_address_bus, a_q, a;
  logic [7:0] data_io_out, data_rd, d;
  logic [7:0] ref_mem [0:2047];
  wire [7:0] data_io_in = data_io_oe ? data_io_out : data_rd;
  int errors = 0;
  int num_checks = 0;
  int seed = 32'h1799;
  int wl = 0;
  // free-running clock
  always #25 sys_clk = ~sys_clk;
  bbsa_ctrl dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .power_ok(power_ok),
    .req_valid(req_valid), .req_cmd(req_cmd), .batt_test(batt_test), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .byte_address_bus(byte_address_bus), .data_io_out(data_io_out),
    .data_io_oe(data_io_oe), .data_io_in(data_io_in));
  bbsa_mem_model mem_u (.power_ok(power_ok), .batt_bad(batt_bad), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .byte_address_bus(byte_address_bus), .data_wr(data_io_out),
    .data_rd(data_rd), .data_drv(data_drv));
  task automatic fail(input string msg);
    errors++;
    $display("wrong value at %0t ns: %s", $time, msg);
  endtask : fail
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp) fail(msg);
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // one request held until its answer, bounded wait
  task automatic do_req(input logic wr, input logic bt, input logic [10:0] ad,
                        input logic [7:0] wd);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (req_ready !== 1'b1) @(negedge sys_clk);
    req_cmd = '{write: wr, addr: ad, wdata: wd};
    req_valid = !bt;
    batt_test = bt;
    while (rsp_valid !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    req_valid = 1'b0;
    batt_test = 1'b0;
    if (n == 40) fail("no answer");
  endtask : do_req
  // write with the reference updated the same way
  task automatic wr_byte(input logic [10:0] ad, input logic [7:0] wd);
    do_req(1'b1, 1'b0, ad, wd);
    if (ref_low) ref_low = 1'b0;
    else ref_mem[ad] = wd;
  endtask : wr_byte
  task automatic rd_byte(input logic [10:0] ad);
    do_req(1'b0, 1'b0, ad, 8'h00);
    check(rsp.rdata, ref_mem[ad], "read data");
  endtask : rd_byte
  task automatic bat_test(input logic [10:0] ad);
    do_req(1'b0, 1'b1, ad, 8'h00);
    check({7'h00, rsp.batt_low}, {7'h00, ref_low}, "battery flag");
    check(rsp.rdata, ref_mem[ad], "test original");
    ref_low = 1'b0;
  endtask : bat_test
  // pin timing watch during writes
  always @(negedge sys_clk) begin
    if (we_n === 1'b0) begin
      wl = wl + 1;
      if (wl > 1 && byte_address_bus !== a_q) fail("address moved in write");
      if (oe_n !== 1'b1 || data_io_oe !== 1'b1) fail("bus not held in write");
    end else begin
      if (power_ok && wl > 0 && wl < bbsa_pkg::WR_PULSE_CYC) fail("short pulse");
      if (power_ok && wl > 0 && data_io_oe !== 1'b1) fail("no data hold");
      if (power_ok && wl > 0 && byte_address_bus !== a_q) fail("no address hold");
      wl = 0;
    end
    if (data_io_oe === 1'b1 && data_drv === 1'b1) fail("bus contention");
    a_q = byte_address_bus;
  end
  // watchdog
  initial begin
    #1000000;
    fail("timeout");
    tally_and_finish();
  end
  // main sequence
  initial begin
    ref_low = 1'b0;
    for (int i = 0; i < 2048; i++) ref_mem[i] = i[7:0] ^ 8'h5A;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    check({5'h00, ce_n, oe_n, we_n}, 8'h07, "pins without power");
    power_ok = 1'b1;
    $display("test reset done");
    for (int k = 0; k < 24; k++) begin
      a = (k == 0) ? 11'h000 : (k == 1) ? 11'h7FF : 11'($random(seed));
      d = 8'($random(seed));
      wr_byte(a, d);
      rd_byte(a);
      rd_byte(a ^ 11'h001);
    end
    $display("test write read done");
    bat_test(11'h055);
    rd_byte(11'h055);
    $display("test battery good done");
    @(negedge sys_clk);
    req_cmd = '{write: 1'b1, addr: 11'h123, wdata: 8'hA5};
    req_valid = 1'b1;
    // cut the supply one cycle into the write pulse
    while (we_n !== 1'b0) @(negedge sys_clk);
    @(negedge sys_clk);
    power_ok = 1'b0;
    req_valid = 1'b0;
    batt_bad = 1'b1;
    repeat (3) @(negedge sys_clk);
    check({5'h00, ce_n, oe_n, we_n}, 8'h07, "pins after power loss");
    power_ok = 1'b1;
    ref_low = 1'b1;
    rd_byte(11'h124);
    bat_test(11'h200);
    rd_byte(11'h200);
    wr_byte(11'h201, 8'h3C);
    rd_byte(11'h201);
    $display("test power fail done");
    tally_and_finish();
  end
endmodule : battery_backed_sram_access_tb
